// *** walker_pkg.sv ***
/*
 * Shared constants and carrier types for the first-level table walker.
 * Assumes a 32-bit physical memory returning one word per read request.
 */
package walker_pkg;

    // Table base register layout
    localparam int TB_HI      = 31;
    localparam int TB_LO      = 14;
    localparam int TB_LOW_W   = 14;
    localparam logic [13:0] TB_LOW_READ = 14'h0000;

    // Modified address fields
    localparam int VA_IDX_HI  = 31;
    localparam int VA_IDX_LO  = 20;
    localparam int PID_HI     = 31;
    localparam int PID_LO     = 25;
    localparam int PID_W      = 7;
    localparam logic [6:0] PID_ZERO = 7'h00;

    // Table geometry
    localparam int L1_ENTRIES     = 4096;
    localparam int COARSE_ENTRIES = 256;
    localparam int FINE_ENTRIES   = 1024;

    // Descriptor fields
    localparam int SEC_BASE_LO = 20;
    localparam int CRS_BASE_LO = 10;
    localparam int FIN_BASE_LO = 12;
    localparam int AP_HI       = 11;
    localparam int AP_LO       = 10;
    localparam int DOM_HI      = 8;
    localparam int DOM_LO      = 5;
    localparam int CB_HI       = 3;
    localparam int CB_LO       = 2;

    // Type encodings in bits [1:0]
    localparam logic [1:0] TYPE_INVALID = 2'h0;
    localparam logic [1:0] TYPE_COARSE  = 2'h1;
    localparam logic [1:0] TYPE_SECTION = 2'h2;
    localparam logic [1:0] TYPE_FINE    = 2'h3;

    typedef enum logic [1:0] {
        KIND_SECTION = 2'b00,
        KIND_COARSE  = 2'b01,
        KIND_FINE    = 2'b10
    } desc_kind_t;

    // Result handed to the TLB and core side
    typedef struct packed {
        desc_kind_t  kind;
        logic [31:0] base;
        logic [1:0]  access_permission_field;
        logic [3:0]  domain;
        logic [1:0]  cache_buf;
        logic [31:0] modified_virt_addr;
    } walk_result_t;

endpackage

// *** first_level_table_walker.sv ***
/*
 * First-level translation table walker: address modification, TLB miss
 * triggered fetch, and descriptor decode to section, coarse, fine or fault.
 * Assumes the TLB lookup answers hit combinationally beside the request,
 * and memory holds rd_addr and returns one word with a valid pulse.
 */
// How it works
// - Modify address with process identifier before translating
// - Walk only when TLB misses
// - Base register low 14 bits read unpredictable
// - Table holds 4096 word entries, 1MB each
// - Fetch address is base[31:14] with address[31:20]
// - Read one word entry as first-level descriptor
// - Always fetch first; pages need second fetch
// - Coarse table: 256 entries of 4KB
// - Fine table: 1024 entries of 1KB
// - Section maps a 1MB physical block
// - Base from [31:20], [31:10] or [31:12]
// - Section permission field from bits [11:10]
// - Section cache attributes from bits [3:2]
// - Type and validity from bits [1:0]
// - Invalid descriptor raises section translation fault
// - Walk automatically and load result to TLB
// - Type 10 decodes as section
// - Type 01 coarse, starts second fetch
// - Type 11 fine, starts second fetch
// - Bits [8:5] select one of 16 domains
module first_level_table_walker #(
    parameter int ADDR_W = 32
) (
    input  wire logic                         ref_clk_i,
    input  wire logic                         reset_n_i,
    // Table base register port
    input  wire logic                         tb_wr_i,
    input  wire logic [31:0]                  tb_wdata_i,
    output logic      [31:0]                  tb_rdata_o,
    input  wire logic [31:0]                  process_identifier_register_i,
    // Core request
    input  wire logic                         req_valid_i,
    input  wire logic [ADDR_W-1:0]            core_virt_addr_i,
    input  wire logic                         tlb_hit_i,
    output logic                              req_ready_o,
    output logic      [ADDR_W-1:0]            modified_virt_addr_o,
    // Memory side
    output logic                              rd_req_o,
    output logic      [29:0]                  rd_word_addr_o,
    input  wire logic                         rd_valid_i,
    input  wire logic [31:0]                  rd_data_i,
    // Results
    output logic                              tlb_load_o,
    output walker_pkg::walk_result_t          result_o,
    output logic                              second_fetch_o,
    output logic                              section_fault_o
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE  = 2'b10
    } walk_state_t;

    walk_state_t       state_q, state_d;
    logic [31:14]      tb_q;
    logic [31:0]       mva_q;
    logic [29:0]       addr_q;
    walker_pkg::walk_result_t res_q, res_d;
    logic              load_q, fault_q, second_q;

    ////////////////////////////////////////////////////////////////////////
    // Address modification and fetch address
    wire logic [6:0] pid_w = process_identifier_register_i[walker_pkg::PID_HI:walker_pkg::PID_LO];
    wire logic       low_w = (core_virt_addr_i[walker_pkg::PID_HI:walker_pkg::PID_LO]
                              == walker_pkg::PID_ZERO);
    // Low 32MB is relocated into the process slot
    wire logic [31:0] mva_w = low_w ? {pid_w, core_virt_addr_i[24:0]} : core_virt_addr_i;
    // Index 12 bits select one of 4096 1MB entries
    wire logic [29:0] fetch_addr_w = {tb_q, mva_w[walker_pkg::VA_IDX_HI:walker_pkg::VA_IDX_LO]};
    wire logic        start_w = (state_q == ST_IDLE) && req_valid_i && !tlb_hit_i;

    ////////////////////////////////////////////////////////////////////////
    // Descriptor decode
    wire logic [1:0] type_w = rd_data_i[1:0];
    wire logic is_sec_w = (type_w == walker_pkg::TYPE_SECTION);
    wire logic is_crs_w = (type_w == walker_pkg::TYPE_COARSE);
    wire logic is_fin_w = (type_w == walker_pkg::TYPE_FINE);
    wire logic is_inv_w = (type_w == walker_pkg::TYPE_INVALID);
    wire logic got_w    = (state_q == ST_FETCH) && rd_valid_i;

    // Base extraction per kind; low bits are zero
    wire logic [31:0] sec_base_w = {rd_data_i[31:walker_pkg::SEC_BASE_LO], 20'h0_0000};
    wire logic [31:0] crs_base_w = {rd_data_i[31:walker_pkg::CRS_BASE_LO], 10'h000};
    wire logic [31:0] fin_base_w = {rd_data_i[31:walker_pkg::FIN_BASE_LO], 12'h000};

    always_comb begin
        res_d = res_q;
        res_d.modified_virt_addr = mva_q;
        res_d.domain = rd_data_i[walker_pkg::DOM_HI:walker_pkg::DOM_LO];
        res_d.access_permission_field = 2'h0;
        res_d.cache_buf = 2'h0;
        if (is_sec_w) begin
            res_d.kind = walker_pkg::KIND_SECTION;
            res_d.base = sec_base_w;
            res_d.access_permission_field = rd_data_i[walker_pkg::AP_HI:walker_pkg::AP_LO];
            res_d.cache_buf = rd_data_i[walker_pkg::CB_HI:walker_pkg::CB_LO];
        end else if (is_crs_w) begin
            res_d.kind = walker_pkg::KIND_COARSE;
            res_d.base = crs_base_w;
        end else begin
            res_d.kind = walker_pkg::KIND_FINE;
            res_d.base = fin_base_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Walk sequencer: one first-level fetch per miss
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  begin
                if (start_w) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (rd_valid_i) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE:  state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // Table base register; low bits are not stored
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tb_q <= 18'h0_0000;
        end else if (tb_wr_i) begin
            tb_q <= tb_wdata_i[walker_pkg::TB_HI:walker_pkg::TB_LO];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            mva_q   <= 32'h0000_0000;
            addr_q  <= 30'h0000_0000;
        end else begin
            state_q <= state_d;
            if (start_w) begin
                mva_q  <= mva_w;
                addr_q <= fetch_addr_w;
            end
        end
    end

    // Result pulses; invalid gives a fault instead of a load
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            res_q    <= '0;
            load_q   <= 1'b0;
            fault_q  <= 1'b0;
            second_q <= 1'b0;
        end else begin
            load_q   <= got_w && !is_inv_w;
            fault_q  <= got_w && is_inv_w;
            second_q <= got_w && (is_crs_w || is_fin_w);
            if (got_w) begin
                res_q <= res_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign tb_rdata_o           = {tb_q, walker_pkg::TB_LOW_READ};
    assign req_ready_o          = (state_q == ST_IDLE);
    assign modified_virt_addr_o = mva_w;
    assign rd_req_o             = (state_q == ST_FETCH);
    assign rd_word_addr_o       = addr_q;
    assign tlb_load_o           = load_q;
    assign result_o             = res_q;
    assign second_fetch_o       = second_q;
    assign section_fault_o      = fault_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    no_walk_hit_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_q == ST_IDLE && tlb_hit_i) |=> state_q == ST_IDLE)
        else $error("walk started on hit");
    fetch_addr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        start_w |=> rd_word_addr_o == {$past(tb_q), $past(mva_w[31:20])})
        else $error("bad fetch address");
    fault_inv_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h0) |=> section_fault_o && !tlb_load_o)
        else $error("invalid without fault");
    sec_base_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h2) |=> result_o.base
        == {$past(rd_data_i[31:20]), 20'h0_0000}
        && result_o.kind == walker_pkg::KIND_SECTION)
        else $error("section base wrong");
    sec_ap_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h2) |=> result_o.access_permission_field
        == $past(rd_data_i[11:10]) && result_o.cache_buf == $past(rd_data_i[3:2]))
        else $error("section attributes wrong");
    second_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[0]) |=> second_fetch_o && tlb_load_o)
        else $error("page table without second fetch");
    domain_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] != 2'h0) |=> result_o.domain == $past(rd_data_i[8:5]))
        else $error("domain wrong");
    one_fetch_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        start_w |=> rd_req_o)
        else $error("no fetch after miss");
    tb_read_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tb_wr_i |=> tb_rdata_o[31:14] == $past(tb_wdata_i[31:14]))
        else $error("base register not stored");
    cov_sec_c:   cover property (@(posedge ref_clk_i) got_w && is_sec_w);
    cov_crs_c:   cover property (@(posedge ref_clk_i) got_w && is_crs_w);
    cov_fin_c:   cover property (@(posedge ref_clk_i) got_w && is_fin_w);
    cov_fault_c: cover property (@(posedge ref_clk_i) got_w && is_inv_w);
    cov_slow_c:  cover property (@(posedge ref_clk_i) (rd_req_o && !rd_valid_i) ##1 rd_req_o);

    // Low addresses take the process slot
    mva_low_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (core_virt_addr_i[31:25] == 7'h00) |-> modified_virt_addr_o[31:25]
        == process_identifier_register_i[31:25])
        else $error("low address not relocated");
    // Low address bits pass unchanged
    mva_tail_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        modified_virt_addr_o[24:0] == core_virt_addr_i[24:0])
        else $error("address tail altered");
    // High addresses pass through whole
    mva_high_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (core_virt_addr_i[31:25] != 7'h00) |-> modified_virt_addr_o == core_virt_addr_i)
        else $error("high address altered");
    // Captured address reaches the result
    mva_keep_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tlb_load_o |-> result_o.modified_virt_addr[31:20] == rd_word_addr_o[11:0])
        else $error("result address mismatch");

    // A hit never reaches memory
    hit_no_fetch_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_q == ST_IDLE && tlb_hit_i) |=> !rd_req_o)
        else $error("fetch on hit");
    // A miss always reaches memory
    miss_fetch_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (req_ready_o && req_valid_i && !tlb_hit_i) |=> rd_req_o)
        else $error("miss without fetch");
    // No request, no fetch
    idle_no_req_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (req_ready_o && !req_valid_i) |=> !rd_req_o)
        else $error("fetch without request");
    // Hit leaves the walker ready
    hit_ready_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (req_ready_o && tlb_hit_i) |=> req_ready_o)
        else $error("hit made walker busy");

    // Low base bits always read as zero here
    tb_low_zero_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tb_rdata_o[13:0] == 14'h0000)
        else $error("base low bits not zero");
    // Base holds without a write
    tb_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !tb_wr_i |=> $stable(tb_rdata_o))
        else $error("base changed without write");
    // Index field is the address top bits
    index_range_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        start_w |=> rd_word_addr_o[11:0] == $past(modified_virt_addr_o[31:20]))
        else $error("table index wrong");
    // Fetch address stands while waiting
    addr_stable_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_req_o && !rd_valid_i) |=> $stable(rd_word_addr_o))
        else $error("fetch address moved");
    // Request stands until data comes
    req_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_req_o && !rd_valid_i) |=> rd_req_o)
        else $error("fetch request dropped early");
    // Exactly one first-level word per walk
    req_drop_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (rd_req_o && rd_valid_i) |=> !rd_req_o)
        else $error("second first-level fetch");
    // Done state returns to ready
    done_ready_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (!req_ready_o && !rd_req_o) |=> req_ready_o)
        else $error("walker stuck after result");
    // Accepted miss makes the walker busy
    start_busy_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        start_w |=> !req_ready_o)
        else $error("walker not busy after miss");

    // Coarse table base and second fetch
    crs_kind_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h1) |=> result_o.kind == walker_pkg::KIND_COARSE
        && result_o.base == {$past(rd_data_i[31:10]), 10'h000} && second_fetch_o)
        else $error("coarse decode wrong");
    // Fine table base and second fetch
    fin_kind_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h3) |=> result_o.kind == walker_pkg::KIND_FINE
        && result_o.base == {$past(rd_data_i[31:12]), 12'h000} && second_fetch_o)
        else $error("fine decode wrong");
    // Section ends after one fetch
    sec_no_second_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] == 2'h2) |=> tlb_load_o && !second_fetch_o)
        else $error("section asked second fetch");
    // Section result covers whole 1MB
    sec_size_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (tlb_load_o && result_o.kind == walker_pkg::KIND_SECTION)
        |-> result_o.base[19:0] == 20'h0_0000)
        else $error("section base not aligned");
    // Coarse table aligned to its 256 words
    crs_align_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (tlb_load_o && result_o.kind == walker_pkg::KIND_COARSE)
        |-> result_o.base[9:0] == 10'h000)
        else $error("coarse base not aligned");
    // Fine table aligned to its 1024 words
    fin_align_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (tlb_load_o && result_o.kind == walker_pkg::KIND_FINE)
        |-> result_o.base[11:0] == 12'h000)
        else $error("fine base not aligned");
    // Page tables carry no section attributes
    page_attr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (tlb_load_o && result_o.kind != walker_pkg::KIND_SECTION)
        |-> result_o.access_permission_field == 2'h0 && result_o.cache_buf == 2'h0)
        else $error("page table attributes set");

    // Load and fault never together
    no_both_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !(tlb_load_o && section_fault_o))
        else $error("load and fault together");
    // Fault only from the invalid encoding
    fault_cause_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        section_fault_o |-> $past(got_w) && $past(rd_data_i[1:0]) == 2'h0)
        else $error("fault without invalid type");
    // Fault never asks a second fetch
    fault_no_second_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        section_fault_o |-> !second_fetch_o)
        else $error("second fetch on fault");
    // Fault returns to ready next cycle
    fault_ready_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        section_fault_o |=> req_ready_o)
        else $error("not ready after fault");
    // Valid descriptor always loads the TLB
    load_after_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (got_w && rd_data_i[1:0] != 2'h0) |=> tlb_load_o)
        else $error("valid descriptor not loaded");
    // Load only follows a fetched word
    load_cause_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tlb_load_o |-> $past(got_w))
        else $error("load without descriptor");
    // Load is a one-cycle pulse
    load_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tlb_load_o |=> !tlb_load_o)
        else $error("load pulse too long");
    // Load is followed by ready
    load_ready_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        tlb_load_o |=> req_ready_o)
        else $error("not ready after load");
    // Result stands between fetches
    result_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !got_w |=> $stable(result_o))
        else $error("result changed without fetch");

endmodule

// *** table_memory_model.sv ***
/*
 * Physical memory model answering first-level descriptor fetches.
 * Assumes the walker holds its read request until it samples valid.
 */
module table_memory_model (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        rd_req_i,
    input  wire logic [31:0] desc_i,
    input  wire logic [3:0]  lat_i,
    output logic             rd_valid_o,
    output logic [31:0]      rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    logic       served_q;
    ////////////////////////////////////////////////////////////////////////
    // One word per fetch after lat_i cycles; idle data toggles, never holds
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_q     <= 4'h0;
            served_q   <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= 32'h0000_0000;
        end else if (rd_req_i && !served_q && wait_q == lat_i) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= desc_i;
            served_q   <= 1'b1;
        end else begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= ~rd_data_o;
            wait_q     <= (rd_req_i && !served_q) ? wait_q + 4'h1 : 4'h0;
            served_q   <= served_q && rd_req_i;
        end
    end
endmodule

// *** tb_first_level_table_walker.sv ***
/*
 * Self-checking bench for the first-level table walker.
 * Assumes the memory model file is compiled first.
 */
module tb_first_level_table_walker;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] va;
        logic [31:0] desc;
    } row_t;
    localparam logic [31:0] TB_VAL = 32'hA5A5_7FFF;
    localparam logic [31:0] PID    = 32'h5400_0000;
    logic                     ref_clk_i, reset_n_i, tb_wr_i, req_valid_i, tlb_hit_i;
    logic                     req_ready_o, rd_req_o, rd_valid_i, tlb_load_o;
    logic                     second_fetch_o, section_fault_o;
    logic [31:0]              tb_wdata_i, tb_rdata_o, core_virt_addr_i, desc, m;
    logic [31:0]              modified_virt_addr_o, rd_data_i, eb;
    logic [29:0]              rd_word_addr_o, got_addr;
    logic [3:0]               lat;
    logic                     got_load, got_fault, got_second;
    walker_pkg::walk_result_t result_o;
    walker_pkg::desc_kind_t   ek;
    int                       n_mismatch, num_checks;
    row_t                     rows [4];
    first_level_table_walker first_level_table_walker_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .tb_wr_i(tb_wr_i),
        .tb_wdata_i(tb_wdata_i), .tb_rdata_o(tb_rdata_o),
        .process_identifier_register_i(PID), .req_valid_i(req_valid_i),
        .core_virt_addr_i(core_virt_addr_i), .tlb_hit_i(tlb_hit_i),
        .req_ready_o(req_ready_o), .modified_virt_addr_o(modified_virt_addr_o),
        .rd_req_o(rd_req_o), .rd_word_addr_o(rd_word_addr_o), .rd_valid_i(rd_valid_i),
        .rd_data_i(rd_data_i), .tlb_load_o(tlb_load_o), .result_o(result_o),
        .second_fetch_o(second_fetch_o), .section_fault_o(section_fault_o));
    table_memory_model table_memory_model_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rd_req_i(rd_req_o),
        .desc_i(desc), .lat_i(lat), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; longest run is well under 2000 cycles
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared compare, request and verdict tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic walk(input logic [31:0] va, input logic hit);
        int i;
        got_addr = '1;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        core_virt_addr_i <= va;
        tlb_hit_i <= hit;
        m = (va[31:25] == 7'h00) ? {PID[31:25], va[24:0]} : va;
        #1 chk(modified_virt_addr_o, m);
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        tlb_hit_i <= 1'b0;
        for (i = 0; i < 20; i++) begin
            #1;
            if (rd_req_o === 1'b1) got_addr = rd_word_addr_o;
            got_load = (tlb_load_o === 1'b1);
            got_fault = (section_fault_o === 1'b1);
            got_second = (second_fetch_o === 1'b1);
            if (got_load || got_fault) break;
            @(posedge ref_clk_i);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register, descriptor table, then awkward cases
    initial begin
        {tb_wr_i, req_valid_i, tlb_hit_i, tb_wdata_i, core_virt_addr_i} = '0;
        {n_mismatch, num_checks, lat, desc, reset_n_i} = '0;
        rows = '{'{32'h0012_3456, 32'h8765_4C1E}, '{32'hFE80_0000, 32'h1234_55F1},
                 '{32'h8000_0000, 32'hABCD_E1F3}, '{32'h4000_0000, 32'hFFFF_FFFC}};
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1 chk({tb_rdata_o, req_ready_o, tlb_load_o, rd_req_o}, 35'h4);
        tb_wr_i <= 1'b1;
        tb_wdata_i <= TB_VAL;
        @(posedge ref_clk_i);
        tb_wr_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 chk(tb_rdata_o, {TB_VAL[31:14], 14'h0000});
        $display("Test reset_and_base done");
        foreach (rows[k]) begin
            desc = rows[k].desc;
            walk(rows[k].va, 1'b0);
            chk(got_addr, {TB_VAL[31:14], m[31:20]});
            chk({got_fault, got_load}, {desc[1:0] == 2'h0, desc[1:0] != 2'h0});
            if (desc[1:0] != 2'h0) begin
                ek = (desc[1:0] == 2'h2) ? walker_pkg::KIND_SECTION :
                     (desc[1:0] == 2'h1) ? walker_pkg::KIND_COARSE : walker_pkg::KIND_FINE;
                eb = (desc[1:0] == 2'h2) ? {desc[31:20], 20'h0_0000} :
                     (desc[1:0] == 2'h1) ? {desc[31:10], 10'h000} : {desc[31:12], 12'h000};
                chk({result_o.kind, result_o.base}, {ek, eb});
                chk(got_second, desc[1:0] != 2'h2);
                chk({result_o.access_permission_field, result_o.cache_buf},
                    (desc[1:0] == 2'h2) ? {desc[11:10], desc[3:2]} : 4'h0);
                chk({result_o.domain, result_o.modified_virt_addr}, {desc[8:5], m});
            end
            $display("Test descriptor row %0d done", k);
        end
        walk(32'h0030_0000, 1'b1);
        chk({got_addr, got_load, got_fault}, {30'h3FFF_FFFF, 2'b00});
        $display("Test tlb_hit done");
        lat = 4'h3;
        desc = rows[0].desc;
        walk(32'hFFF0_0000, 1'b0);
        chk({got_addr, got_load}, {TB_VAL[31:14], 12'hFFF, 1'b1});
        chk(result_o.base, {desc[31:20], 20'h0_0000});
        $display("Test slow_memory done");
        test_done();
    end
endmodule
